// *** common/perf_monitor_pkg.sv ***
// Purpose: constants, codes and carriers of the performance monitoring unit
// Assumes: registers sit behind the core's coprocessor register port
// Notes: register address is {crn, crm}
// Contract
// [R01] global enable low stops all counters; high lets them all count
// [R02] interrupt enables: bit 0 cycle counter, bits 4:1 event counters, reset zero
// [R03] overflow flags: bit 0 cycle counter, bits 4:1 event counters, reset zero
// [R04] writing 1 clears an overflow flag; writing 0 leaves it
// [R05] event select holds four 8-bit codes, counter 3 in bits 31:24
// [R06] interrupt asserts while any flag and its enable are both set
// [R07] interrupt stays until flag cleared; clearing the enable also drops it
// [R08] clearing global enable does not drop a pending interrupt
// [R09] counters keep counting after wrapping while enabled
// [R10] software disables counting before changing event selection
// [R11] code 0xFF idles a counter; global enable low idles the unit
// [R12] codes 0x0, 0x3, 0x4 count icache miss fetches, itlb and dtlb misses
// [R13] codes 0x1, 0x2, 0x8 count every cycle their condition holds
// [R14] code 0x9 counts each contiguous run of buffer-full stall cycles once
// [R15] code 0x5 counts direct branches; 0x6 counts mispredicted ones
// [R16] code 0x7 counts executed instructions only
// [R17] code 0xA counts data cache accesses, not maintenance operations
// [R18] multi-register transfers count per register; doubleword load counts two
// [R19] code 0xB counts data and mini data cache misses
// [R20] code 0xC counts each half line written back
// [R21] code 0xD counts software program counter changes, not exception vectoring
// [R22] reserved or unlisted codes never increment
// [R23] cycle counter wraps from all ones to zero and sets flag bit 0
// [R24] event counter wrap sets its flag bit, 1 to 4
// [R25] divider bit makes the cycle counter advance once per 64 clocks
// [R26] control bits zero event counters or cycle counter; writing 0 does nothing
package perf_monitor_pkg;
	localparam int NUM_EVT = 4;
	localparam int ACC_W = 3;
	localparam int CYCLE_COUNTER_DIV = 64;
	localparam logic [7:0] ADDR_CTRL = 8'h01;
	localparam logic [7:0] ADDR_CYCLE_COUNTER = 8'h11;
	localparam logic [7:0] ADDR_INTEN = 8'h41;
	localparam logic [7:0] ADDR_FLAG = 8'h51;
	localparam logic [7:0] ADDR_EVENT_SOURCE_SELECT = 8'h81;
	localparam logic [7:0] ADDR_EVT0 = 8'h02;
	localparam logic [3:0] CRM_EVT = 4'h2;
	localparam int CTRL_E = 0;
	localparam int CTRL_P = 1;
	localparam int CTRL_C = 2;
	localparam int CTRL_D = 3;
	localparam int CTRL_ID_LSB = 24;
	localparam logic [7:0] UNIT_ID = 8'h5a; // arbitrary value
	localparam logic [4:0] INTEN_RESET = 5'h00;
	localparam logic [4:0] FLAG_RESET = 5'h00;
	localparam logic [31:0] EVENT_SOURCE_SELECT_RESET = 32'hffff_ffff;
	localparam logic [31:0] CNT_RESET = 32'h0000_0000;
	localparam logic [31:0] CNT_MAX = 32'hffff_ffff;
	localparam logic [7:0] EVT_IC_MISS = 8'h00;
	localparam logic [7:0] EVT_IF_STALL = 8'h01;
	localparam logic [7:0] EVT_DEP_STALL = 8'h02;
	localparam logic [7:0] EVT_ITLB_MISS = 8'h03;
	localparam logic [7:0] EVT_DTLB_MISS = 8'h04;
	localparam logic [7:0] EVT_BRANCH = 8'h05;
	localparam logic [7:0] EVT_MISPRED = 8'h06;
	localparam logic [7:0] EVT_INSTR = 8'h07;
	localparam logic [7:0] EVT_BUF_CYC = 8'h08;
	localparam logic [7:0] EVT_BUF_RUN = 8'h09;
	localparam logic [7:0] EVT_DC_ACCESS = 8'h0a;
	localparam logic [7:0] EVT_DC_MISS = 8'h0b;
	localparam logic [7:0] EVT_DC_WB = 8'h0c;
	localparam logic [7:0] EVT_PC_CHANGE = 8'h0d;
	localparam logic [7:0] EVT_IDLE = 8'hff;

	typedef struct packed {
		logic ic_miss_fetch;
		logic if_stall;
		logic dep_stall;
		logic itlb_miss;
		logic dtlb_miss;
		logic branch_exec;
		logic branch_mispred;
		logic instr_exec;
		logic dbuf_full;
		logic [ACC_W-1:0] dc_access_cnt;
		logic dc_miss;
		logic dc_wb_half;
		logic sw_pc_change;
	} evt_strobes_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [31:0] wdata;
	} cp_req_t;
endpackage

// *** logic/event_select_decode.sv ***
// Purpose: turn one counter's event code into an increment amount
// Assumes: strobes are single-cycle per occurrence, levels for durations
// Notes: combinational only
`timescale 1ns/1ns
module event_select_decode (
	input logic [7:0] code,
	input perf_monitor_pkg::evt_strobes_t ev,
	input logic buf_run_start,
	output logic [perf_monitor_pkg::ACC_W-1:0] inc
);
	localparam logic [perf_monitor_pkg::ACC_W-1:0] ONE = 1;
	localparam logic [perf_monitor_pkg::ACC_W-1:0] ZERO = 0;

	function automatic logic [perf_monitor_pkg::ACC_W-1:0] one_if(input logic b);
		return b ? ONE : ZERO;
	endfunction

	always_comb begin
		case (code)
			perf_monitor_pkg::EVT_IC_MISS: inc = one_if(ev.ic_miss_fetch); // R12
			perf_monitor_pkg::EVT_IF_STALL: inc = one_if(ev.if_stall); // R13
			perf_monitor_pkg::EVT_DEP_STALL: inc = one_if(ev.dep_stall); // R13
			perf_monitor_pkg::EVT_ITLB_MISS: inc = one_if(ev.itlb_miss); // R12
			perf_monitor_pkg::EVT_DTLB_MISS: inc = one_if(ev.dtlb_miss); // R12
			perf_monitor_pkg::EVT_BRANCH: inc = one_if(ev.branch_exec); // R15
			perf_monitor_pkg::EVT_MISPRED: inc = one_if(ev.branch_mispred); // R15
			perf_monitor_pkg::EVT_INSTR: inc = one_if(ev.instr_exec); // R16
			perf_monitor_pkg::EVT_BUF_CYC: inc = one_if(ev.dbuf_full); // R13
			perf_monitor_pkg::EVT_BUF_RUN: inc = one_if(buf_run_start); // R14
			perf_monitor_pkg::EVT_DC_ACCESS: inc = ev.dc_access_cnt; // R17 R18
			perf_monitor_pkg::EVT_DC_MISS: inc = one_if(ev.dc_miss); // R19
			perf_monitor_pkg::EVT_DC_WB: inc = one_if(ev.dc_wb_half); // R20
			perf_monitor_pkg::EVT_PC_CHANGE: inc = one_if(ev.sw_pc_change); // R21
			default: inc = ZERO; // R22 R11
		endcase
	end
endmodule

// *** logic/cycle_prescaler.sv ***
// Purpose: cycle counter advance enable, every clock or once per DIV clocks
// Assumes: run low freezes the divider so nothing toggles
// Notes: divider restarts when the divide bit is cleared
`timescale 1ns/1ns
module cycle_prescaler #(
	parameter int DIV = perf_monitor_pkg::CYCLE_COUNTER_DIV
) (
	input logic clock,
	input logic rst,
	input logic run,
	input logic div_en,
	output logic tick
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] ZERO = '0;

	logic [CW-1:0] cnt_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_r <= ZERO;
		end else if (!div_en) begin
			cnt_r <= ZERO;
		end else if (run) begin
			cnt_r <= (cnt_r == LAST) ? ZERO : cnt_r + CW'(1);
		end
	end

	assign tick = run && (!div_en || cnt_r == LAST); // R25
endmodule

// *** logic/perf_monitor_unit.sv ***
// Purpose: four event counters, a cycle counter, overflow flags and interrupt
// Assumes: coprocessor port is synchronous; one access per cycle
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/1ns
module perf_monitor_unit (
	input logic clock,
	input logic rst,
	input perf_monitor_pkg::cp_req_t cp_req,
	input perf_monitor_pkg::evt_strobes_t events,
	output logic [31:0] rdata,
	output logic rvalid,
	output logic irq
);
	localparam int N = perf_monitor_pkg::NUM_EVT;
	localparam int AW = perf_monitor_pkg::ACC_W;

	function automatic logic [32:0] bump(input logic [31:0] v, input logic [AW-1:0] n);
		return {1'b0, v} + {30'h0000_0000, n};
	endfunction

	logic [7:0] addr;
	logic wr_ctrl;
	logic wr_cycle_counter;
	logic wr_inten;
	logic wr_flag;
	logic wr_event_source_select;
	logic [N-1:0] wr_evt;
	logic reset_evt;
	logic reset_cycle_counter;

	logic enable_r;
	logic div_r;
	logic [4:0] inten_r;
	logic [4:0] flag_r;
	logic [4:0] flag_nxt;
	logic [31:0] event_source_select_r;
	logic [31:0] cycle_counter_r;
	logic [31:0] evt_cnt_r [N];
	logic buf_full_q_r;
	logic buf_run_start;
	logic cycle_counter_tick;
	logic [32:0] cycle_counter_sum;
	logic [4:0] ovf_set;
	logic [31:0] rdata_nxt;

	assign addr = {cp_req.crn, cp_req.crm};
	assign wr_ctrl = cp_req.wr && addr == perf_monitor_pkg::ADDR_CTRL;
	assign wr_cycle_counter = cp_req.wr && addr == perf_monitor_pkg::ADDR_CYCLE_COUNTER;
	assign wr_inten = cp_req.wr && addr == perf_monitor_pkg::ADDR_INTEN;
	assign wr_flag = cp_req.wr && addr == perf_monitor_pkg::ADDR_FLAG;
	assign wr_event_source_select = cp_req.wr && addr == perf_monitor_pkg::ADDR_EVENT_SOURCE_SELECT;
	assign reset_evt = wr_ctrl && cp_req.wdata[perf_monitor_pkg::CTRL_P]; // R26
	assign reset_cycle_counter = wr_ctrl && cp_req.wdata[perf_monitor_pkg::CTRL_C]; // R26

	// control: enable and divider live, reset bits are strobes only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			enable_r <= 1'b0;
			div_r <= 1'b0;
		end else if (wr_ctrl) begin
			enable_r <= cp_req.wdata[perf_monitor_pkg::CTRL_E]; // R01
			div_r <= cp_req.wdata[perf_monitor_pkg::CTRL_D]; // R25
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			inten_r <= perf_monitor_pkg::INTEN_RESET; // R02
		end else if (wr_inten) begin
			inten_r <= cp_req.wdata[4:0]; // R02
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			event_source_select_r <= perf_monitor_pkg::EVENT_SOURCE_SELECT_RESET;
		end else if (wr_event_source_select) begin
			event_source_select_r <= cp_req.wdata; // R05 R10
		end
	end

	// run start detector for buffer-full stalls, held still while idle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buf_full_q_r <= 1'b0;
		end else if (enable_r) begin
			buf_full_q_r <= events.dbuf_full;
		end
	end

	assign buf_run_start = events.dbuf_full && !buf_full_q_r; // R14

	cycle_prescaler #(
		.DIV(perf_monitor_pkg::CYCLE_COUNTER_DIV)
	) u_prescaler (
		.clock(clock),
		.rst(rst),
		.run(enable_r),
		.div_en(div_r),
		.tick(cycle_counter_tick)
	);

	assign cycle_counter_sum = bump(cycle_counter_r, AW'(1));

	// cycle counter: reset strobe beats a write, a write beats counting
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cycle_counter_r <= perf_monitor_pkg::CNT_RESET;
		end else if (reset_cycle_counter) begin
			cycle_counter_r <= perf_monitor_pkg::CNT_RESET; // R26
		end else if (wr_cycle_counter) begin
			cycle_counter_r <= cp_req.wdata;
		end else if (cycle_counter_tick) begin
			cycle_counter_r <= cycle_counter_sum[31:0]; // R23 R09
		end
	end

	assign ovf_set[0] = cycle_counter_tick && !reset_cycle_counter && !wr_cycle_counter && cycle_counter_sum[32]; // R23

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_evt
			logic [7:0] code;
			logic [AW-1:0] inc;
			logic [32:0] sum;
			logic counting;

			assign code = event_source_select_r[8*gi +: 8]; // R05
			assign wr_evt[gi] = cp_req.wr && cp_req.crm == perf_monitor_pkg::CRM_EVT
				&& cp_req.crn == 4'(gi);

			event_select_decode u_decode (
				.code(code),
				.ev(events),
				.buf_run_start(buf_run_start),
				.inc(inc)
			);

			assign counting = enable_r && code != perf_monitor_pkg::EVT_IDLE; // R01 R11
			assign sum = bump(evt_cnt_r[gi], inc);

			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					evt_cnt_r[gi] <= perf_monitor_pkg::CNT_RESET;
				end else if (reset_evt) begin
					evt_cnt_r[gi] <= perf_monitor_pkg::CNT_RESET; // R26
				end else if (wr_evt[gi]) begin
					evt_cnt_r[gi] <= cp_req.wdata;
				end else if (counting && inc != '0) begin
					evt_cnt_r[gi] <= sum[31:0]; // R09
				end
			end

			assign ovf_set[gi+1] = counting && !reset_evt && !wr_evt[gi] && sum[32]; // R24
		end
	endgenerate

	// flags: a hardware set in the clearing cycle wins
	always_comb begin
		flag_nxt = flag_r;
		if (wr_flag) begin
			flag_nxt = flag_r & ~cp_req.wdata[4:0]; // R04
		end
		flag_nxt = flag_nxt | ovf_set; // R03
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flag_r <= perf_monitor_pkg::FLAG_RESET; // R03
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// request depends on flags and enables only, never on global enable
	assign irq = |(flag_r & inten_r); // R06 R07 R08

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (addr)
			perf_monitor_pkg::ADDR_CTRL: begin
				rdata_nxt[31:perf_monitor_pkg::CTRL_ID_LSB] = perf_monitor_pkg::UNIT_ID;
				rdata_nxt[perf_monitor_pkg::CTRL_D] = div_r;
				rdata_nxt[perf_monitor_pkg::CTRL_E] = enable_r;
			end
			perf_monitor_pkg::ADDR_CYCLE_COUNTER: rdata_nxt = cycle_counter_r;
			perf_monitor_pkg::ADDR_INTEN: rdata_nxt[4:0] = inten_r; // R02
			perf_monitor_pkg::ADDR_FLAG: rdata_nxt[4:0] = flag_r;
			perf_monitor_pkg::ADDR_EVENT_SOURCE_SELECT: rdata_nxt = event_source_select_r;
			default: begin
				if (cp_req.crm == perf_monitor_pkg::CRM_EVT && cp_req.crn < 4'(N)) begin
					rdata_nxt = evt_cnt_r[cp_req.crn[1:0]];
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
			rvalid <= 1'b0;
		end else begin
			rvalid <= cp_req.rd;
			if (cp_req.rd) begin
				rdata <= rdata_nxt;
			end
		end
	end

	// checks
	logic [7:0] rd_addr_q;
	logic no_wr;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_addr_q <= 8'h00;
		end else if (cp_req.rd) begin
			rd_addr_q <= addr;
		end
	end

	assign no_wr = !cp_req.wr;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_disable_freeze: assert property ( // R01
		!enable_r && no_wr |=> $stable(evt_cnt_r[0]) && $stable(cycle_counter_r))
		else $error("counter moved while disabled");
	a_inten_reserved: assert property ( // R02
		rvalid && rd_addr_q == perf_monitor_pkg::ADDR_INTEN |-> rdata[31:5] == 27'h0)
		else $error("enable register reserved bits not zero");
	a_cycle_counter_wrap: assert property ( // R23
		enable_r && !div_r && no_wr && cycle_counter_r == perf_monitor_pkg::CNT_MAX
		|=> cycle_counter_r == perf_monitor_pkg::CNT_RESET && flag_r[0])
		else $error("cycle counter wrap wrong");
	a_flag_clear_one: assert property ( // R04
		wr_flag && cp_req.wdata[1] && !ovf_set[1] |=> !flag_r[1])
		else $error("flag not cleared by one");
	a_flag_zero_keeps: assert property ( // R04
		wr_flag && !cp_req.wdata[2] && flag_r[2] |=> flag_r[2])
		else $error("flag lost on zero write");
	a_irq_survives_off: assert property ( // R08
		irq && wr_ctrl && !cp_req.wdata[perf_monitor_pkg::CTRL_E] |=> irq[*2])
		else $error("interrupt dropped by disabling");
	a_irq_from_flag: assert property ( // R06
		$rose(flag_r[2]) && inten_r[2] |-> irq)
		else $error("overflow with enable gave no interrupt");
	a_idle_code: assert property ( // R11
		event_source_select_r[15:8] == perf_monitor_pkg::EVT_IDLE && no_wr |=> $stable(evt_cnt_r[1]))
		else $error("idle counter moved");
	a_div_spacing: assert property ( // R25
		cycle_counter_tick && div_r && no_wr |=> (!cycle_counter_tick)[*8])
		else $error("divided cycle counter advanced too soon");
	a_counter_reset: assert property ( // R26
		reset_evt |=> evt_cnt_r[0] == perf_monitor_pkg::CNT_RESET
			&& evt_cnt_r[3] == perf_monitor_pkg::CNT_RESET)
		else $error("event counters not zeroed");
	a_evt_wrap_flag: assert property ( // R24
		ovf_set[2] |=> flag_r[2] && evt_cnt_r[1] < 32'h0000_0008)
		else $error("event counter wrap not flagged");
	a_run_once: assert property ( // R14
		event_source_select_r[7:0] == perf_monitor_pkg::EVT_BUF_RUN && enable_r && no_wr
		&& events.dbuf_full && buf_full_q_r |=> $stable(evt_cnt_r[0]))
		else $error("stall run counted twice");

	// flag and interrupt request paths
	a_flag_set_wins: assert property ( // R04
		ovf_set != 5'h00
		|=> (flag_r & $past(ovf_set)) == $past(ovf_set))
		else $error("overflow lost against a clearing write");

	a_flag_reserved: assert property ( // R03
		rvalid && rd_addr_q == perf_monitor_pkg::ADDR_FLAG
		|-> rdata[31:5] == 27'h000_0000)
		else $error("flag register reserved bits not zero");

	a_irq_enable_drop: assert property ( // R07
		wr_inten && ((flag_r | ovf_set) & cp_req.wdata[4:0]) == 5'h00
		|=> !irq)
		else $error("interrupt kept after enable cleared");

	a_irq_flag_drop: assert property ( // R07
		wr_flag && (((flag_r & ~cp_req.wdata[4:0]) | ovf_set) & inten_r) == 5'h00
		|=> !irq)
		else $error("interrupt kept after flag cleared");

	a_inten_write: assert property ( // R02
		wr_inten |=> inten_r == $past(cp_req.wdata[4:0]))
		else $error("interrupt enables not written");

	// control register effects
	a_cycle_count: assert property ( // R01
		enable_r && !div_r && no_wr
		|=> cycle_counter_r == $past(cycle_counter_r) + 32'h0000_0001)
		else $error("cycle counter missed a clock");

	a_cycle_counter_reset: assert property ( // R26
		reset_cycle_counter |=> cycle_counter_r == perf_monitor_pkg::CNT_RESET)
		else $error("cycle counter not zeroed");

	a_zero_ctrl_noop: assert property ( // R26
		wr_ctrl && !cp_req.wdata[perf_monitor_pkg::CTRL_P]
		&& !cp_req.wdata[perf_monitor_pkg::CTRL_C] && !enable_r
		|=> $stable(evt_cnt_r[1]) && $stable(cycle_counter_r))
		else $error("zero reset bits changed a counter");

	// event code decoding
	a_reserved_code: assert property ( // R22
		event_source_select_r[23:16] > perf_monitor_pkg::EVT_PC_CHANGE && no_wr
		|=> $stable(evt_cnt_r[2]))
		else $error("reserved code counted");

	a_miss_count: assert property ( // R12
		event_source_select_r[31:24] == perf_monitor_pkg::EVT_IC_MISS && enable_r && no_wr
		&& events.ic_miss_fetch
		|=> evt_cnt_r[3] == $past(evt_cnt_r[3]) + 32'h0000_0001)
		else $error("miss occurrence not counted once");

	a_level_count: assert property ( // R13
		event_source_select_r[7:0] == perf_monitor_pkg::EVT_DEP_STALL && enable_r && no_wr
		&& events.dep_stall
		|=> evt_cnt_r[0] == $past(evt_cnt_r[0]) + 32'h0000_0001)
		else $error("stall cycle not counted");

	a_instr_count: assert property ( // R16
		event_source_select_r[7:0] == perf_monitor_pkg::EVT_INSTR && enable_r && no_wr
		&& events.instr_exec
		|=> evt_cnt_r[0] == $past(evt_cnt_r[0]) + 32'h0000_0001)
		else $error("executed instruction not counted");

	a_access_multi: assert property ( // R18
		event_source_select_r[7:0] == perf_monitor_pkg::EVT_DC_ACCESS && enable_r && no_wr
		&& events.dc_access_cnt == 3'h2
		|=> evt_cnt_r[0] == $past(evt_cnt_r[0]) + 32'h0000_0002)
		else $error("multiple accesses not counted per access");

	a_pc_change: assert property ( // R21
		event_source_select_r[31:24] == perf_monitor_pkg::EVT_PC_CHANGE && enable_r && no_wr
		&& events.sw_pc_change
		|=> evt_cnt_r[3] == $past(evt_cnt_r[3]) + 32'h0000_0001)
		else $error("program counter change not counted");

	a_run_first: assert property ( // R14
		event_source_select_r[7:0] == perf_monitor_pkg::EVT_BUF_RUN && enable_r && no_wr
		&& events.dbuf_full && !buf_full_q_r
		|=> evt_cnt_r[0] == $past(evt_cnt_r[0]) + 32'h0000_0001)
		else $error("stall run start not counted");

	c_evt_overflow: cover property (ovf_set[2]);
	c_irq_rise: cover property ($rose(irq));
	c_div_tick: cover property (div_r && cycle_counter_tick);
	c_buf_run: cover property (buf_run_start && enable_r);
	c_cycle_counter_wrap: cover property (ovf_set[0]);
endmodule

// *** tb/core_event_source.sv ***
// Purpose: core side event strobes feeding the monitor
// Assumes: strobes change just after a rising edge
// Notes: vector bits follow the strobe struct, msb first
`timescale 1ns/1ns
module core_event_source (
	input wire logic clock,
	output perf_monitor_pkg::evt_strobes_t events
);
	logic [14:0] ev_r = 15'h0000;
	assign events = perf_monitor_pkg::evt_strobes_t'(ev_r);
	// occurrences are single pulses with an idle cycle between, durations hold a level
	task automatic drive(input logic [14:0] v, input int n, input bit level);
		repeat (n) begin
			@(posedge clock);
			ev_r <= v;
			if (!level) begin
				@(posedge clock);
				ev_r <= 15'h0000;
			end
		end
		@(posedge clock);
		ev_r <= 15'h0000;
	endtask
endmodule

// *** tb/tb.sv ***
// Purpose: self-checking bench of the performance monitor
// Assumes: one register access per task call
// Notes: expected values are worked out from the codes and counts driven
`timescale 1ns/1ns
module tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	perf_monitor_pkg::cp_req_t cp_req = '0;
	perf_monitor_pkg::evt_strobes_t events;
	logic [31:0] rdata;
	logic rvalid;
	logic irq;
	int fails = 0;
	int num_checks = 0;
	logic [31:0] id_w = {perf_monitor_pkg::UNIT_ID, 24'h00_0000};
	perf_monitor_unit i_perf_monitor_unit (
		.clock(clock), .rst(rst), .cp_req(cp_req), .events(events),
		.rdata(rdata), .rvalid(rvalid), .irq(irq));
	core_event_source i_core_event_source (.clock(clock), .events(events));
	always #5 clock = ~clock;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_irq(input logic exp);
		@(negedge clock);
		num_checks++;
		if (irq !== exp) begin
			fails++;
			$display("mismatch at %0t: irq %b expected %b", $time, irq, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		cp_req <= '{1'b1, 1'b0, a[7:4], a[3:0], d};
		@(posedge clock);
		cp_req.wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		cp_req <= '{1'b0, 1'b1, a[7:4], a[3:0], 32'h0000_0000};
		@(posedge clock);
		cp_req.rd <= 1'b0;
		@(negedge clock);
		chk({rvalid, rdata}, {1'b1, exp});
	endtask
	function automatic logic [14:0] ev_vec(input int c);
		if (c == 10)
			return 15'h0010;
		if (c == 9)
			return 15'h0040;
		if (c <= 8)
			return 15'h4000 >> c;
		return 15'h0004 >> (c - 11);
	endfunction

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		stop_test();
	end

	initial begin
		logic [7:0] cd;
		logic [31:0] n;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rd_reg(perf_monitor_pkg::ADDR_CTRL, id_w);
		rd_reg(perf_monitor_pkg::ADDR_INTEN, 32'h0000_0000);
		rd_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0000);
		rd_reg(perf_monitor_pkg::ADDR_EVENT_SOURCE_SELECT, perf_monitor_pkg::EVENT_SOURCE_SELECT_RESET);
		rd_reg(8'h77, 32'h0000_0000);
		wr_reg(perf_monitor_pkg::ADDR_INTEN, 32'hffff_ffff);
		rd_reg(perf_monitor_pkg::ADDR_INTEN, 32'h0000_001f);
		wr_reg(perf_monitor_pkg::ADDR_INTEN, 32'h0000_0000);
		// counters 0 and 3 count the code, 1 idles, 2 holds a reserved code
		for (int c = 0; c < 14; c++) begin
			cd = c[7:0];
			n = (c == 9) ? 32'h0000_0002 : (c == 10) ? 32'h0000_000c : 32'h0000_0006;
			wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0000);
			wr_reg(perf_monitor_pkg::ADDR_EVENT_SOURCE_SELECT, {cd, 8'h10, 8'hff, cd});
			wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0003);
			repeat (2) i_core_event_source.drive(ev_vec(c), 3, c inside {1, 2, 8, 9});
			wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0000);
			rd_reg({4'h0, perf_monitor_pkg::CRM_EVT}, n);
			rd_reg({4'h1, perf_monitor_pkg::CRM_EVT}, 32'h0000_0000);
			rd_reg({4'h2, perf_monitor_pkg::CRM_EVT}, 32'h0000_0000);
			rd_reg({4'h3, perf_monitor_pkg::CRM_EVT}, n);
		end
		rd_reg(perf_monitor_pkg::ADDR_EVENT_SOURCE_SELECT, 32'h0d10_ff0d);
		wr_reg(perf_monitor_pkg::ADDR_EVENT_SOURCE_SELECT, 32'h0000_0700);
		wr_reg(8'h12, 32'hffff_fffe);
		wr_reg(perf_monitor_pkg::ADDR_INTEN, 32'h0000_0004);
		i_core_event_source.drive(15'h0080, 3, 1'b0);
		rd_reg(8'h12, 32'hffff_fffe);
		wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0001);
		i_core_event_source.drive(15'h0080, 3, 1'b0);
		wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0000);
		rd_reg(8'h12, 32'h0000_0001);
		rd_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0004);
		chk_irq(1'b1);
		wr_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0000);
		rd_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0004);
		wr_reg(perf_monitor_pkg::ADDR_INTEN, 32'h0000_0000);
		chk_irq(1'b0);
		wr_reg(perf_monitor_pkg::ADDR_INTEN, 32'h0000_0004);
		chk_irq(1'b1);
		wr_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0006);
		chk_irq(1'b0);
		rd_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0000);
		// cycle counter counts the two edges up to and including the disabling write
		wr_reg(perf_monitor_pkg::ADDR_CYCLE_COUNTER, 32'hffff_ffff);
		wr_reg(perf_monitor_pkg::ADDR_INTEN, 32'h0000_0001);
		wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0001);
		wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0000);
		rd_reg(perf_monitor_pkg::ADDR_CYCLE_COUNTER, 32'h0000_0001);
		rd_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0001);
		chk_irq(1'b1);
		wr_reg(perf_monitor_pkg::ADDR_FLAG, 32'h0000_0001);
		chk_irq(1'b0);
		// about 160 enabled clocks sit well inside two divided ticks
		wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_000d);
		rd_reg(perf_monitor_pkg::ADDR_CTRL, id_w | 32'h0000_0009);
		repeat (155) @(posedge clock);
		wr_reg(perf_monitor_pkg::ADDR_CTRL, 32'h0000_0000);
		rd_reg(perf_monitor_pkg::ADDR_CYCLE_COUNTER, 32'h0000_0002);
		stop_test();
	end
endmodule
